/* common/fcdma_pkg.sv */
// shared constants of the five channel transfer core; no outside assumptions.
package fcdma_pkg;
  // ----------------------------------------------------------------
  // channel count and control byte layout (D0 is the msb)
  // ----------------------------------------------------------------
  localparam int NCH = 5;
  localparam int CTRL_SEL_HI = 5;  // D2
  localparam int CTRL_SEL_LO = 4;  // D3
  localparam int CTRL_EN = 3;      // D4
  localparam int CTRL_HALF = 2;    // D5
  localparam int CTRL_SRC_INC = 1; // D6
  localparam int CTRL_DST_INC = 0; // D7
  localparam logic [1:0] SEL_00 = 2'h0;
  localparam logic [1:0] SEL_01 = 2'h1;
  localparam logic [1:0] SEL_10 = 2'h2;
  localparam logic [1:0] SEL_11 = 2'h3;
  // ----------------------------------------------------------------
  // address window, buffer shape, reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] WINDOW_HI = 16'h0080;
  localparam int DATA_W = 16;
  localparam int BUF_DEPTH = 2;
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [7:0] CNT_RST = 8'hff;
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_HALF = 16'h0002;
  localparam logic [4:0] RING_BYTE_STEP = 5'h01;
  localparam logic [5:0] RING_HALF_STEP = 6'h02;
  typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_READ, ST_WRITE} fcdma_state_e;
endpackage : fcdma_pkg

/* hdl/fcdma_buf2.sv */
// two entry holding buffer between the read and the write bus cycle.
// assumes the drain side may stall for any number of cycles.
`timescale 1ns/1ps
`default_nettype none
module fcdma_buf2 #(
  parameter int W = fcdma_pkg::DATA_W,
  parameter int D = fcdma_pkg::BUF_DEPTH
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [W-1:0] in_data_in,
  // drain side
  input wire logic out_ready_in,
  output logic out_valid_out,
  output logic [W-1:0] out_data_out
);
  logic [W-1:0] mem_q [D];
  logic [$clog2(D)-1:0] wp_q, rp_q;
  logic [$clog2(D):0] cnt_q;
  logic push, pop;

  // honest full and empty from the occupancy count
  assign in_ready_out = (cnt_q != ($clog2(D)+1)'(D));
  assign out_valid_out = (cnt_q != '0);
  assign out_data_out = mem_q[rp_q];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_ready_in && out_valid_out;

  // storage has no reset, only the pointers and the count need one
  always_ff @(posedge mclk_in) begin
    if (push) begin
      mem_q[wp_q] <= in_data_in;
    end
  end

  // pointers wrap at the depth
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == ($clog2(D))'(D-1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == ($clog2(D))'(D-1)) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_q + ($clog2(D)+1)'(push) - ($clog2(D)+1)'(pop);
    end
  end
endmodule : fcdma_buf2
`default_nettype wire

/* hdl/fcdma_trigsel.sv */
// request source selection for the five channels.
// assumes all event inputs are one-cycle pulses on mclk_in.
`timescale 1ns/1ps
`default_nettype none
module fcdma_trigsel (
  // selectors and software starts
  input wire logic [4:0][1:0] sel_in,
  input wire logic [4:0] sw_req_in,
  // per channel unit transfer completion
  input wire logic [4:0] unit_done_in,
  // peripheral events
  input wire logic adc_done_in,
  input wire logic io_timer8_underflow_in,
  input wire logic in_event_line2_in,
  input wire logic out_event_line0_in,
  input wire logic out_event_line1_in,
  input wire logic timer_input_13_in,
  input wire logic timer_input_18_in,
  input wire logic timer_input_19_in,
  input wire logic sio0_tx_empty_in,
  input wire logic sio0_rx_done_in,
  input wire logic sio1_rx_done_in,
  // selected trigger per channel
  output logic [4:0] trig_out
);
  // one case per channel (an if chain for channel 3), decoded from its own selector
  always_comb begin
    trig_out = '0;
    case (sel_in[0])
      fcdma_pkg::SEL_00: trig_out[0] = sw_req_in[0] | unit_done_in[2];
      fcdma_pkg::SEL_01: trig_out[0] = adc_done_in;
      fcdma_pkg::SEL_10: trig_out[0] = io_timer8_underflow_in;
      default: trig_out[0] = in_event_line2_in;
    endcase
    case (sel_in[1])
      fcdma_pkg::SEL_00: trig_out[1] = sw_req_in[1];
      fcdma_pkg::SEL_01: trig_out[1] = out_event_line0_in;
      fcdma_pkg::SEL_10: trig_out[1] = timer_input_13_in;
      default: trig_out[1] = unit_done_in[0];
    endcase
    case (sel_in[2])
      fcdma_pkg::SEL_00: trig_out[2] = sw_req_in[2];
      fcdma_pkg::SEL_01: trig_out[2] = out_event_line1_in;
      fcdma_pkg::SEL_10: trig_out[2] = timer_input_18_in;
      default: trig_out[2] = unit_done_in[1];
    endcase
    // upper bit alone picks serial 1 receive
    if (sel_in[3][1]) begin
      trig_out[3] = sio1_rx_done_in;
    end else if (sel_in[3][0]) begin
      trig_out[3] = sio0_tx_empty_in;
    end else begin
      trig_out[3] = sw_req_in[3];
    end
    case (sel_in[4])
      fcdma_pkg::SEL_00: trig_out[4] = sw_req_in[4];
      fcdma_pkg::SEL_01: trig_out[4] = unit_done_in[3];
      fcdma_pkg::SEL_10: trig_out[4] = sio0_rx_done_in;
      default: trig_out[4] = timer_input_19_in;
    endcase
  end
endmodule : fcdma_trigsel
`default_nettype wire

/* hdl/fcdma_core.sv */
// five channel transfer core: trigger pick, fixed priority, dual address moves.
// assumes the bus owner grants by level and ends each cycle with bus_ready_in;
// all event pulses arrive from logic on mclk_in.
`timescale 1ns/1ps
`default_nettype none
module fcdma_core (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // channel control bytes (D0 msb) and ring mode
  input wire logic [4:0][7:0] ch_ctrl_in,
  input wire logic [4:0] ch_ring_mode_in,
  // software starts, one pulse per write
  input wire logic [4:0] ch_sw_req_in,
  // address and count loads
  input wire logic [4:0] ch_src_load_in,
  input wire logic [4:0] ch_dst_load_in,
  input wire logic [4:0] ch_cnt_load_in,
  input wire logic [15:0] load_addr_in,
  input wire logic [7:0] load_cnt_in,
  // completion status and masks
  input wire logic [4:0] irq_status_clr_in,
  input wire logic [4:0] irq_mask_in,
  // peripheral events
  input wire logic adc_done_in,
  input wire logic io_timer8_underflow_in,
  input wire logic in_event_line2_in,
  input wire logic out_event_line0_in,
  input wire logic out_event_line1_in,
  input wire logic timer_input_13_in,
  input wire logic timer_input_18_in,
  input wire logic timer_input_19_in,
  input wire logic sio0_tx_empty_in,
  input wire logic sio0_rx_done_in,
  input wire logic sio1_rx_done_in,
  // internal bus master side
  output logic bus_req_out,
  input wire logic bus_grant_in,
  output logic bus_rd_out,
  output logic bus_wr_out,
  output logic [31:0] bus_addr_out,
  output logic [1:0] bus_be_out,
  output logic [15:0] bus_wdata_out,
  input wire logic [15:0] bus_rdata_in,
  input wire logic bus_ready_in,
  // channel state readback
  output logic [4:0] ch_enable_out,
  output logic [4:0] ch_pending_out,
  output logic [4:0][15:0] ch_src_out,
  output logic [4:0][15:0] ch_dst_out,
  output logic [4:0][7:0] ch_cnt_out,
  output logic [4:0] ch_unit_done_out,
  output logic [4:0] irq_status_out,
  output logic irq_out
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // next address after one unit; ring mode wraps low five or six bits
  function automatic logic [15:0] next_addr(input logic [15:0] a, input logic inc,
                                           input logic half, input logic ring);
    logic [15:0] r;
    r = a;
    if (!inc) begin
      r = a;
    end else if (ring && half) begin
      r = {a[15:6], a[5:0] + fcdma_pkg::RING_HALF_STEP};
    end else if (ring) begin
      r = {a[15:5], a[4:0] + fcdma_pkg::RING_BYTE_STEP};
    end else begin
      r = a + (half ? fcdma_pkg::STEP_HALF : fcdma_pkg::STEP_BYTE);
    end
    return r;
  endfunction : next_addr

  // lane enables: even byte is the upper lane, halfwords use both
  function automatic logic [1:0] lane_be(input logic half, input logic lsb);
    logic [1:0] r;
    r = 2'h3;
    if (!half) begin
      r = lsb ? 2'h1 : 2'h2;
    end
    return r;
  endfunction : lane_be

  // full bus address; the lsb is dropped for halfwords
  function automatic logic [31:0] bus_addr(input logic [15:0] a, input logic half);
    return {fcdma_pkg::WINDOW_HI, a[15:1], a[0] & ~half};
  endfunction : bus_addr

  // lowest numbered request wins
  function automatic logic [2:0] prio_pick(input logic [4:0] req);
    logic [2:0] r;
    r = 3'h0;
    for (int i = fcdma_pkg::NCH - 1; i >= 0; i--) begin
      if (req[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction : prio_pick

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  fcdma_pkg::fcdma_state_e state_q;
  logic [2:0] cur_q;
  logic [4:0] pend_q, ended_q, irq_q;
  logic [4:0][15:0] src_q, dst_q;
  logic [4:0][7:0] cnt_q;
  logic [31:0] addr_q;
  logic [1:0] be_q;
  logic [4:0] active, trig, unit_done, can_go;
  logic [4:0][1:0] sel;
  logic cur_half, cur_ring, underflow;
  logic buf_in_ready, buf_out_valid, buf_push, buf_pop;
  logic [15:0] rd_placed, buf_data;
  logic [7:0] rd_byte;

  // ----------------------------------------------------------------
  // channel status and triggers
  // ----------------------------------------------------------------

  // hardware end holds until software drops the enable bit
  always_comb begin
    for (int c = 0; c < fcdma_pkg::NCH; c++) begin
      active[c] = ch_ctrl_in[c][fcdma_pkg::CTRL_EN] & ~ended_q[c];
      sel[c] = {ch_ctrl_in[c][fcdma_pkg::CTRL_SEL_HI], ch_ctrl_in[c][fcdma_pkg::CTRL_SEL_LO]};
      unit_done[c] = buf_pop && (cur_q == 3'(c));
    end
  end

  fcdma_trigsel u_trigsel (
    .sel_in(sel),
    .sw_req_in(ch_sw_req_in),
    .unit_done_in(unit_done),
    .adc_done_in(adc_done_in),
    .io_timer8_underflow_in(io_timer8_underflow_in),
    .in_event_line2_in(in_event_line2_in),
    .out_event_line0_in(out_event_line0_in),
    .out_event_line1_in(out_event_line1_in),
    .timer_input_13_in(timer_input_13_in),
    .timer_input_18_in(timer_input_18_in),
    .timer_input_19_in(timer_input_19_in),
    .sio0_tx_empty_in(sio0_tx_empty_in),
    .sio0_rx_done_in(sio0_rx_done_in),
    .sio1_rx_done_in(sio1_rx_done_in),
    .trig_out(trig)
  );

  // a fresh trigger in the completing cycle survives the clear
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pend_q <= '0;
    end else begin
      pend_q <= ((pend_q & ~unit_done) | trig) & active;
    end
  end

  // ----------------------------------------------------------------
  // sequencer: arbitrate, hold bus, read, write, release
  // ----------------------------------------------------------------
  assign can_go = pend_q & active;
  assign cur_half = ch_ctrl_in[cur_q][fcdma_pkg::CTRL_HALF];
  assign cur_ring = ch_ring_mode_in[cur_q];
  assign underflow = (cnt_q[cur_q] == '0) && !cur_ring;

  // priority is looked at again from idle after each unit
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= fcdma_pkg::ST_IDLE;
      cur_q <= 3'h0;
    end else begin
      case (state_q)
        fcdma_pkg::ST_IDLE: begin
          if (|can_go) begin
            cur_q <= prio_pick(can_go);
            state_q <= fcdma_pkg::ST_REQ;
          end
        end
        fcdma_pkg::ST_REQ: begin
          if (bus_grant_in) begin
            state_q <= fcdma_pkg::ST_READ;
          end
        end
        fcdma_pkg::ST_READ: begin
          if (buf_push) begin
            state_q <= fcdma_pkg::ST_WRITE;
          end
        end
        default: begin
          if (buf_pop) begin
            state_q <= fcdma_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // address and lanes are registered so the bus sees steady values
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      addr_q <= '0;
      be_q <= '0;
    end else if (state_q == fcdma_pkg::ST_REQ && bus_grant_in) begin
      addr_q <= bus_addr(src_q[cur_q], cur_half);
      be_q <= lane_be(cur_half, src_q[cur_q][0]);
    end else if (buf_push) begin
      addr_q <= bus_addr(dst_q[cur_q], cur_half);
      be_q <= lane_be(cur_half, dst_q[cur_q][0]);
    end
  end

  // bus is held from request to the end of the write, at least three cycles
  assign bus_req_out = (state_q != fcdma_pkg::ST_IDLE);
  assign bus_rd_out = (state_q == fcdma_pkg::ST_READ);
  assign bus_wr_out = (state_q == fcdma_pkg::ST_WRITE) && buf_out_valid;
  assign bus_addr_out = addr_q;
  assign bus_be_out = be_q;
  assign bus_wdata_out = buf_data;

  // ----------------------------------------------------------------
  // data path: for bytes pick source lane and copy to both lanes, halfwords pass whole, hold in buffer
  // ----------------------------------------------------------------
  assign rd_byte = src_q[cur_q][0] ? bus_rdata_in[7:0] : bus_rdata_in[15:8];
  assign rd_placed = cur_half ? bus_rdata_in : {rd_byte, rd_byte};
  assign buf_push = bus_rd_out && bus_ready_in && buf_in_ready;
  assign buf_pop = bus_wr_out && bus_ready_in;

  fcdma_buf2 #(
    .W(fcdma_pkg::DATA_W),
    .D(fcdma_pkg::BUF_DEPTH)
  ) u_buf (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .in_valid_in(bus_rd_out && bus_ready_in),
    .in_ready_out(buf_in_ready),
    .in_data_in(rd_placed),
    .out_ready_in(bus_wr_out && bus_ready_in),
    .out_valid_out(buf_out_valid),
    .out_data_out(buf_data)
  );

  // ----------------------------------------------------------------
  // per channel address, count and end bookkeeping
  // ----------------------------------------------------------------

  // addresses step only when the write completes
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      src_q <= {fcdma_pkg::NCH{fcdma_pkg::ADDR_RST}};
      dst_q <= {fcdma_pkg::NCH{fcdma_pkg::ADDR_RST}};
    end else begin
      for (int c = 0; c < fcdma_pkg::NCH; c++) begin
        if (unit_done[c]) begin
          src_q[c] <= next_addr(src_q[c], ch_ctrl_in[c][fcdma_pkg::CTRL_SRC_INC],
                                cur_half, cur_ring);
          dst_q[c] <= next_addr(dst_q[c], ch_ctrl_in[c][fcdma_pkg::CTRL_DST_INC],
                                cur_half, cur_ring);
        end else begin
          if (ch_src_load_in[c]) begin
            src_q[c] <= load_addr_in;
          end
          if (ch_dst_load_in[c]) begin
            dst_q[c] <= load_addr_in;
          end
        end
      end
    end
  end

  // counter is write protected while the channel is enabled
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= {fcdma_pkg::NCH{fcdma_pkg::CNT_RST}};
    end else begin
      for (int c = 0; c < fcdma_pkg::NCH; c++) begin
        if (unit_done[c]) begin
          cnt_q[c] <= cnt_q[c] - 8'h01;
        end else if (ch_cnt_load_in[c] && !ch_ctrl_in[c][fcdma_pkg::CTRL_EN]) begin
          cnt_q[c] <= load_cnt_in;
        end
      end
    end
  end

  // the end latch stands in for the cleared enable bit
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ended_q <= '0;
    end else begin
      for (int c = 0; c < fcdma_pkg::NCH; c++) begin
        if (unit_done[c] && underflow) begin
          ended_q[c] <= 1'b1;
        end else if (!ch_ctrl_in[c][fcdma_pkg::CTRL_EN]) begin
          ended_q[c] <= 1'b0;
        end
      end
    end
  end

  // completion status is sticky; a set in the clear cycle wins
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_q <= '0;
    end else begin
      for (int c = 0; c < fcdma_pkg::NCH; c++) begin
        if (unit_done[c] && underflow) begin
          irq_q[c] <= 1'b1;
        end else if (irq_status_clr_in[c]) begin
          irq_q[c] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // readback
  // ----------------------------------------------------------------
  assign ch_enable_out = active;
  assign ch_pending_out = pend_q;
  assign ch_src_out = src_q;
  assign ch_dst_out = dst_q;
  assign ch_cnt_out = cnt_q;
  assign ch_unit_done_out = unit_done;
  assign irq_status_out = irq_q;
  assign irq_out = |(irq_q & ~irq_mask_in);
endmodule : fcdma_core
`default_nettype wire

/* tb/fcdma_bus_model.sv */
// bus partner: grant, optional wait states and a small word memory.
// assumes the core holds each bus cycle until bus_ready_out is high.
`timescale 1ns/1ps
`default_nettype none
module fcdma_bus_model (
  // clock, reset, pacing
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic fast_in,
  // core side
  input wire logic bus_req_in,
  input wire logic bus_rd_in,
  input wire logic bus_wr_in,
  input wire logic [31:0] bus_addr_in,
  input wire logic [1:0] bus_be_in,
  input wire logic [15:0] bus_wdata_in,
  // answers
  output logic bus_grant_out,
  output logic [15:0] bus_rdata_out,
  output logic bus_ready_out
);
  logic [15:0] mem [256];
  logic [15:0] last_q = 16'h0000;
  logic slow_q;
  // per-address pattern, lanes differ so a wrong lane shows up
  initial for (int i = 0; i < 256; i++) mem[i] = {8'(i) ^ 8'ha5, 8'(i)};
  // slow pacing toggles, so grant and every ready come one cycle late
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      slow_q <= 1'b0;
    end else begin
      slow_q <= bus_req_in & ~slow_q;
    end
  end
  assign bus_grant_out = bus_req_in & (fast_in | slow_q);
  assign bus_ready_out = (bus_rd_in | bus_wr_in) & (fast_in | slow_q);
  // outside a completed read the data lines show a changed value, not stale data
  assign bus_rdata_out = (bus_rd_in & bus_ready_out) ? mem[bus_addr_in[8:1]] : ~last_q;
  // lane writes on completion
  always @(posedge mclk_in) begin
    if (bus_rd_in && bus_ready_out) last_q <= bus_rdata_out;
    if (bus_wr_in && bus_ready_out && bus_be_in[1]) mem[bus_addr_in[8:1]][15:8] <= bus_wdata_in[15:8];
    if (bus_wr_in && bus_ready_out && bus_be_in[0]) mem[bus_addr_in[8:1]][7:0] <= bus_wdata_in[7:0];
  end
endmodule : fcdma_bus_model
`default_nettype wire

/* tb/fcdma_checker.sv */
// concurrent checks on the core's bus and channel ports.
// assumes one clock domain; bound to the core below.
`timescale 1ns/1ps
`default_nettype none
module fcdma_checker (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // watched ports
  input wire logic [4:0][7:0] ch_ctrl_in,
  input wire logic bus_ready_in,
  input wire logic bus_req_out,
  input wire logic bus_rd_out,
  input wire logic bus_wr_out,
  input wire logic [31:0] bus_addr_out,
  input wire logic [1:0] bus_be_out,
  input wire logic [4:0] ch_enable_out,
  input wire logic [4:0] ch_pending_out,
  input wire logic [4:0][7:0] ch_cnt_out,
  input wire logic [4:0] ch_unit_done_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  logic cyc_on;
  // any bus cycle in flight
  assign cyc_on = bus_rd_out | bus_wr_out;
  sequence s_unit_hold;
    bus_req_out [*3];
  endsequence
  a_unit_three: assert property ($rose(bus_req_out) |-> s_unit_hold)
    else $error("bus held under three cycles");
  a_wr_after_rd: assert property ($rose(bus_wr_out) |-> $past(bus_rd_out) && $past(bus_ready_in))
    else $error("write without completed read");
  a_bus_release: assert property (bus_wr_out && bus_ready_in |=> !bus_req_out && !bus_rd_out)
    else $error("bus kept after write");
  a_addr_window: assert property (cyc_on |-> bus_addr_out[31:16] == 16'h0080)
    else $error("address outside window");
  a_half_align: assert property (cyc_on && bus_be_out == 2'h3 |-> !bus_addr_out[0])
    else $error("unaligned halfword");
  a_byte_lane: assert property (cyc_on && bus_be_out != 2'h3 |-> bus_be_out == (bus_addr_out[0] ? 2'h1 : 2'h2))
    else $error("wrong byte lane");
  a_cascade_req: assert property (ch_unit_done_out[0] && ch_ctrl_in[1][5:4] == 2'h3 && ch_enable_out[1] |=> ch_pending_out[1])
    else $error("cascade request lost");
  a_cnt_step: assert property (ch_unit_done_out[0] |=> ch_cnt_out[0] == $past(ch_cnt_out[0]) - 8'h01)
    else $error("count not stepped");
endmodule : fcdma_checker
bind fcdma_core fcdma_checker u_chk (.mclk_in, .rst_n_in, .ch_ctrl_in, .bus_ready_in, .bus_req_out,
  .bus_rd_out, .bus_wr_out, .bus_addr_out, .bus_be_out, .ch_enable_out, .ch_pending_out,
  .ch_cnt_out, .ch_unit_done_out);
`default_nettype wire

/* tb/tb_fcdma_core.sv */
// self-checking bench for the transfer core against the bus partner model.
// assumes the checker binds itself to the core.
`timescale 1ns/1ps
`default_nettype none
module tb_fcdma_core;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic fast = 1'b1;
  logic [4:0][7:0] ctrl = '0;
  logic [4:0] ring = '0, swr = '0, sld = '0, dld = '0, cld = '0, sclr = '0, mask = '0;
  logic [15:0] la = '0;
  logic [7:0] lc = '0;
  logic [10:0] ev = '0;
  logic req, gnt, rd, wr, rdy, irq;
  logic [31:0] addr;
  logic [1:0] be;
  logic [15:0] wdata, rdata;
  logic [4:0] en, pend, done, stat;
  logic [4:0][15:0] src, dst;
  logic [4:0][7:0] cnt;
  logic [4:0] order [$];
  logic [15:0] tbl [12] = '{16'h0100, 16'h0201, 16'h0302, 16'h1103, 16'h1205, 16'h2104,
    16'h2206, 16'h3108, 16'h320a, 16'h330a, 16'h4209, 16'h4307};
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;
  always #5 mclk_in = ~mclk_in;
  fcdma_core uut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .ch_ctrl_in(ctrl), .ch_ring_mode_in(ring),
    .ch_sw_req_in(swr), .ch_src_load_in(sld), .ch_dst_load_in(dld), .ch_cnt_load_in(cld),
    .load_addr_in(la), .load_cnt_in(lc), .irq_status_clr_in(sclr), .irq_mask_in(mask),
    .adc_done_in(ev[0]), .io_timer8_underflow_in(ev[1]), .in_event_line2_in(ev[2]),
    .out_event_line0_in(ev[3]), .out_event_line1_in(ev[4]), .timer_input_13_in(ev[5]),
    .timer_input_18_in(ev[6]), .timer_input_19_in(ev[7]), .sio0_tx_empty_in(ev[8]),
    .sio0_rx_done_in(ev[9]), .sio1_rx_done_in(ev[10]), .bus_req_out(req), .bus_grant_in(gnt),
    .bus_rd_out(rd), .bus_wr_out(wr), .bus_addr_out(addr), .bus_be_out(be),
    .bus_wdata_out(wdata), .bus_rdata_in(rdata), .bus_ready_in(rdy), .ch_enable_out(en),
    .ch_pending_out(pend), .ch_src_out(src), .ch_dst_out(dst), .ch_cnt_out(cnt),
    .ch_unit_done_out(done), .irq_status_out(stat), .irq_out(irq));
  fcdma_bus_model u_bus (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .fast_in(fast),
    .bus_req_in(req), .bus_rd_in(rd), .bus_wr_in(wr), .bus_addr_in(addr), .bus_be_in(be),
    .bus_wdata_in(wdata), .bus_grant_out(gnt), .bus_rdata_out(rdata), .bus_ready_out(rdy));
  task automatic final_report;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [31:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // inputs always move 1 ns after the rising edge
  task automatic step(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask : step
  task automatic sw(input int k);
    swr[k] = 1'b1;
    step(1);
    swr[k] = 1'b0;
  endtask : sw
  task automatic pulse(input logic [3:0] b);
    ev[b] = 1'b1;
    step(1);
    ev[b] = 1'b0;
  endtask : pulse
  // count load only takes while disabled, so call before enabling
  task automatic load(input int k, input logic [15:0] s, d, input logic [7:0] c);
    la = s;
    lc = c;
    sld[k] = 1'b1;
    cld[k] = 1'b1;
    step(1);
    sld[k] = 1'b0;
    cld[k] = 1'b0;
    la = d;
    dld[k] = 1'b1;
    step(1);
    dld[k] = 1'b0;
  endtask : load
  task automatic idle;
    for (int i = 0; i < 80 && (pend !== 5'h00 || req !== 1'b0); i++) step(1);
    chk("idle", 6'h00, {pend, req});
  endtask : idle
  // unit order as seen at write completion
  always @(posedge mclk_in) if (|done) order.push_back(done);
  // hang guard
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      final_report();
    end
  end
  initial begin
    step(5);
    rst_n_in = 1'b1;
    // halfwords, both addresses stepping, count 2 gives three units
    load(0, 16'h0010, 16'h0041, 8'h02);
    ctrl[0] = 8'h0f;
    repeat (3) begin
      sw(0);
      idle();
    end
    chk("s1 word", 16'had08, u_bus.mem[8'h20]);
    chk("s1 last", 16'haf0a, u_bus.mem[8'h22]);
    chk("s1 src", 16'h0016, src[0]);
    chk("s1 dst", 16'h0047, dst[0]);
    chk("s1 cnt", 8'hff, cnt[0]);
    chk("s1 end", 3'h3, {en[0], stat[0], irq});
    mask = 5'h01;
    step(1);
    chk("s1 mask", 1'h0, irq);
    ctrl[0] = 8'h00;
    // bytes with slow partner: fixed odd source into stepping even destination
    fast = 1'b0;
    load(2, 16'h0031, 16'h0060, 8'h01);
    ctrl[2] = 8'h09;
    repeat (2) begin
      sw(2);
      idle();
    end
    chk("s2 lanes", 16'h1818, u_bus.mem[8'h30]);
    chk("s2 src", 16'h0031, src[2]);
    chk("s2 dst", 16'h0062, dst[2]);
    ctrl[2] = 8'h00;
    fast = 1'b1;
    // ch0 and ch4 together, ch1 cascaded behind ch0 must beat ch4
    ctrl[0] = 8'h08;
    ctrl[1] = 8'h38;
    ctrl[4] = 8'h08;
    order.delete();
    swr = 5'h11;
    step(1);
    swr = 5'h00;
    idle();
    chk("s3 units", 3, order.size());
    chk("s3 first", 5'h01, order[0]);
    chk("s3 second", 5'h02, order[1]);
    chk("s3 third", 5'h10, order[2]);
    ctrl = '0;
    // cascade loop 0->1->2->0 with 3->4 behind it; ch0 count 1 stops the loop
    load(0, 16'h0016, 16'h0047, 8'h01);
    ctrl = {8'h18, 8'h08, 8'h38, 8'h38, 8'h08};
    order.delete();
    swr = 5'h09;
    step(1);
    swr = 5'h00;
    idle();
    chk("s4 units", 8, order.size());
    chk("s4 third", 5'h04, order[2]);
    chk("s4 fourth", 5'h01, order[3]);
    chk("s4 seventh", 5'h08, order[6]);
    chk("s4 eighth", 5'h10, order[7]);
    chk("s4 end", 2'h1, {en[0], stat[0]});
    ctrl = '0;
    // ring bytes: count 0 must not end, low five bits wrap
    ring[3] = 1'b1;
    load(3, 16'h0000, 16'h009f, 8'h00);
    ctrl[3] = 8'h09;
    sw(3);
    idle();
    chk("ring dst", 16'h0080, dst[3]);
    chk("ring run", 10'h2ff, {en[3], stat[3], cnt[3]});
    // halfword ring on ch4: low six bits wrap from 3e back to 00
    ring[4] = 1'b1;
    load(4, 16'h00fe, 16'h0000, 8'h00);
    ctrl[4] = 8'h0e;
    sw(4);
    idle();
    chk("ring half", 16'h00c0, src[4]);
    ctrl = '0;
    ring = '0;
    // every peripheral source, first disabled then enabled
    foreach (tbl[i]) begin
      ctrl[tbl[i][15:12]] = {2'h0, tbl[i][9:8], 4'h0};
      pulse(tbl[i][3:0]);
      chk("src off", 5'h00, pend);
      ctrl[tbl[i][15:12]][3] = 1'b1;
      step(1);
      pulse(tbl[i][3:0]);
      chk("src on", 5'h01 << tbl[i][15:12], pend);
      idle();
      ctrl = '0;
    end
    sclr = 5'h1f;
    step(1);
    sclr = 5'h00;
    chk("clear", 5'h00, stat);
    final_report();
  end
endmodule : tb_fcdma_core
`default_nettype wire
